// ==== qfr_pkg.sv ====
// Purpose: Shared constants, state type and decode functions of the quad fast read engine
// Assumes: Three-byte addressing only; memory array lives outside the engine
// Notes: All event counts are counts of sampled serial clock edges
`default_nettype none

package qfr_pkg;

  // ---------------------------------------------------------------
  // Command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_QUAD_READ = 8'hEB;
  localparam logic [7:0] OP_DTR_QUAD_READ = 8'hED;
  localparam logic [7:0] OP_SET_WRAP = 8'h77;
  localparam logic [7:0] OP_FL_WRAP_READ = 8'h0C;

  // ---------------------------------------------------------------
  // Phase lengths in sampling events and serial clocks
  // ---------------------------------------------------------------
  localparam logic [5:0] OPC_EVENTS_SPI = 6'h08;
  localparam logic [5:0] OPC_EVENTS_FL = 6'h02;
  localparam logic [5:0] ADDR_EVENTS = 6'h06;
  localparam logic [5:0] MODE_EVENTS = 6'h02;
  localparam logic [5:0] WRAP_CMD_EVENTS = 6'h20;
  localparam logic [5:0] SPI_DUMMY_CLOCKS = 6'h04;
  localparam logic [5:0] FL_SDR_DUMMY_BASE = 6'h04;
  localparam logic [5:0] FL_DDR_DUMMY_BASE = 6'h06;
  localparam logic [5:0] MODE_CLOCKS_SDR = 6'h02;
  localparam logic [5:0] MODE_CLOCKS_DDR = 6'h01;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int MODE_SEL_LSB = 4;
  localparam logic [1:0] CONT_MODE_KEY = 2'h2;
  localparam int WRAP_ENABLE_POS = 0;
  localparam int WRAP_LEN_LSB = 1;
  localparam logic WRAP_ENABLE_ACTIVE = 1'b0;
  localparam logic [2:0] WRAP_SETTING_RESET = 3'h7;
  localparam logic [5:0] SYNC_RESET_VALUE = 6'h20;

  typedef enum logic [2:0] {
    ST_IDLE, ST_OPCODE, ST_ADDR, ST_MODE, ST_DUMMY, ST_DATA, ST_WRAPCFG, ST_IGNORE
  } qfr_state_t;

  // Section mask for 8, 16, 32 or 64 byte wrap
  function automatic logic [7:0] qfr_wrap_mask(input logic [1:0] len);
    case (len)
      2'h0: return 8'h07;
      2'h1: return 8'h0F;
      2'h2: return 8'h1F;
      default: return 8'h3F;
    endcase
  endfunction : qfr_wrap_mask

  // Next byte address, confined to its section when wrapping
  function automatic logic [23:0] qfr_next_addr(input logic [23:0] a, input logic wrapOn,
                                                input logic [1:0] len);
    logic [23:0] m;
    logic [23:0] inc;
    m = {16'h0000, qfr_wrap_mask(len)};
    inc = a + 24'h000001;
    if (wrapOn)
      return (a & ~m) | (inc & m);
    return inc;
  endfunction : qfr_next_addr

  // Dummy clocks left after the mode byte
  function automatic logic [5:0] qfr_dummy_after_mode(input logic fl, input logic ddr,
                                                      input logic [2:0] p);
    logic [5:0] total;
    total = (ddr ? FL_DDR_DUMMY_BASE : FL_SDR_DUMMY_BASE) + {2'h0, p, 1'b0};
    if (!fl)
      return SPI_DUMMY_CLOCKS;
    return total - (ddr ? MODE_CLOCKS_DDR : MODE_CLOCKS_SDR);
  endfunction : qfr_dummy_after_mode

endpackage : qfr_pkg

`default_nettype wire

// ==== qfr_pin_sync.sv ====
// Purpose: Two-stage synchroniser for the serial pins
// Assumes: Inputs are asynchronous to clk
// Notes: Only the second stage may be read by other logic
`default_nettype none

module qfr_pin_sync #(
  parameter int WIDTH = 6,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  // Two flops; metastability settles in the first
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      stage1_reg <= RESET_VAL;
      stage2_reg <= RESET_VAL;
    end
    else
    begin
      stage1_reg <= asyncIn;
      stage2_reg <= stage1_reg;
    end
  end

  assign syncOut = stage2_reg;

endmodule : qfr_pin_sync

`default_nettype wire

// ==== qfr_engine.sv ====
// Purpose: Flash-side quad IO fast read engine (single and double rate) with wrap setup
// Assumes: Serial pins sampled by a much faster clk; memData valid 4 clk after memAddr
// Notes: Serial clock and chip select are oversampled, never used as clocks
//
// What this block does
// RULE1: After quad read opcode take address, mode byte, four dummy clocks on rising edges.
// RULE2: After dummy phase drive memory data on all four IO lines, a nibble per clock.
// RULE3: Start at any byte address, advance address by one after each output byte.
// RULE4: Host sets quad enable first; quad read performed only while quad enable set. Code checks it at the opcode only; continuous frames skip it.
// RULE5: Mode select bits equal 10: next frame starts directly with the address.
// RULE6: Mode select bits other than 10: next frame needs full opcode again.
// RULE7: Host may clear mode select bits with a reset command before normal commands.
// RULE8: Wrap command setting applies to subsequent single-line-mode quad reads.
// RULE9: Wrapping confines data to aligned 8, 16, 32 or 64 byte section of page.
// RULE10: Wrapped output starts at given address, returns to section start until deselect.
// RULE11: Wrap setting bit 4 enables wrap, bits 6:5 choose section length.
// RULE12: Four-line command mode quad read dummy count 4 to 18 from parameters, default 4.
// RULE13: Four-line command mode counts mode byte inside dummy clocks; data follows at default.
// RULE14: Four-line command mode also supports opcode-free continuous quad reads.
// RULE15: Four-line command mode quad read never wraps; wrapped reads use dedicated opcode.
// RULE16: Double-rate quad read: address and data on four lines, four dummy clocks, quad enable.
// RULE17: Host may send any low mode nibble, must release IO before first data edge.
// RULE18: Double-rate mode select 10: next frame takes address right after select.
// RULE19: Wrap command setting also applies to following double-rate reads.
// RULE20: Four-line command mode double-rate dummy 6 to 20, default 6, including mode byte.
// RULE21: Host wrap setup: opcode, 24 dummy bits, 8 wrap bits, then deselect.
// RULE22: Double-rate read moves address and data on both serial clock edges.
`default_nettype none

module qfr_engine
  import qfr_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic csPinN,
  input wire logic sckPin,
  input wire logic [3:0] ioPinIn,
  output logic [3:0] ioPinOut,
  output logic [3:0] ioPinOe,
  input wire logic quadEnableBit,
  input wire logic fourLineCommandMode,
  input wire logic [2:0] readParamBits,
  input wire logic contModeClear,
  output logic [23:0] memAddr,
  input wire logic [7:0] memData,
  output logic [7:0] continuousModeByte,
  output logic continuousModeSelectActive,
  output logic [2:0] wrapSettingBits
);

  // ---------------------------------------------------------------
  // Pin sampling
  // ---------------------------------------------------------------
  logic [5:0] pinSync;
  logic csN;
  logic sck;
  logic [3:0] ioIn;
  logic sckPrev_reg;
  logic csPrev_reg;
  logic sckRise;
  logic sckFall;
  logic csFall;

  qfr_pin_sync #(
    .WIDTH(6),
    .RESET_VAL(SYNC_RESET_VALUE)
  ) u_pin_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .asyncIn({csPinN, sckPin, ioPinIn}),
    .syncOut(pinSync)
  );

  assign csN = pinSync[5];
  assign sck = pinSync[4];
  assign ioIn = pinSync[3:0];

  // Previous synced levels for edge finding
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sckPrev_reg <= 1'b0;
      csPrev_reg <= 1'b1;
    end
    else
    begin
      sckPrev_reg <= sck;
      csPrev_reg <= csN;
    end
  end

  assign sckRise = sck & ~sckPrev_reg;
  assign sckFall = ~sck & sckPrev_reg;
  assign csFall = ~csN & csPrev_reg;

  // ---------------------------------------------------------------
  // Frame state
  // ---------------------------------------------------------------
  qfr_state_t state_reg;
  logic [5:0] cnt_reg;
  logic [23:0] shift_reg;
  logic [23:0] shift_next;
  logic ddr_reg;
  logic wrapCmd_reg;
  logic wrapOn_reg;
  logic nibLow_reg;
  logic contMode_reg;
  logic contDdr_reg;
  logic contWrapCmd_reg;
  logic [7:0] modeByte_reg;
  logic [2:0] wrapSetting_reg;
  logic [3:0] ioOut_reg;
  logic ioOe_reg;
  logic [23:0] memAddr_reg;
  logic sampleEv;
  logic outEv;
  logic lastEv;
  logic opDone;
  logic addrDone;
  logic modeDone;
  logic dummyDone;
  logic wrapDone;
  logic [7:0] opWord;
  logic quadOp;

  // Falls only count in the second half of a double-rate clock [RULE22]
  assign sampleEv = (state_reg == ST_ADDR || state_reg == ST_MODE) &&
                    (sckRise || (ddr_reg && sckFall && cnt_reg[0]));
  assign outEv = (state_reg == ST_DATA) && (sckFall || (ddr_reg && sckRise)); // [RULE22]
  assign lastEv = (cnt_reg == 6'h01);
  assign opDone = (state_reg == ST_OPCODE) && sckRise && lastEv;
  assign addrDone = (state_reg == ST_ADDR) && sampleEv && lastEv;
  assign modeDone = (state_reg == ST_MODE) && sampleEv && lastEv;
  assign dummyDone = (state_reg == ST_DUMMY) && sckRise && lastEv;
  assign wrapDone = (state_reg == ST_WRAPCFG) && sckRise && lastEv;
  assign opWord = shift_next[7:0];
  // Dedicated wrapped read exists only in four-line command mode [RULE15]
  assign quadOp = (opWord == OP_QUAD_READ) || (opWord == OP_DTR_QUAD_READ) ||
                  (fourLineCommandMode && opWord == OP_FL_WRAP_READ);

  // Bit collector: one line for single-line opcodes and wrap setup bits, four otherwise
  always_comb
  begin
    shift_next = shift_reg;
    if (state_reg == ST_OPCODE && sckRise)
      shift_next = fourLineCommandMode ? {shift_reg[19:0], ioIn} : {shift_reg[22:0], ioIn[0]};
    else if (state_reg == ST_WRAPCFG && sckRise)
      shift_next = {shift_reg[22:0], ioIn[0]};
    else if (sampleEv)
      shift_next = {shift_reg[19:0], ioIn}; // [RULE1] [RULE16]
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      shift_reg <= 24'h000000;
    else if (csFall)
      shift_reg <= 24'h000000;
    else
      shift_reg <= shift_next;
  end

  // Phase sequencing; deselect always ends the frame
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_reg <= ST_IDLE;
      cnt_reg <= 6'h00;
      ddr_reg <= 1'b0;
      wrapCmd_reg <= 1'b0;
    end
    else if (csN)
      state_reg <= ST_IDLE;
    else
    begin
      case (state_reg)
        ST_IDLE:
          if (csFall && contMode_reg)
          begin
            // Opcode skipped, address first [RULE5] [RULE14] [RULE18]
            state_reg <= ST_ADDR;
            cnt_reg <= ADDR_EVENTS;
            ddr_reg <= contDdr_reg;
            wrapCmd_reg <= contWrapCmd_reg;
          end
          else if (csFall)
          begin
            state_reg <= ST_OPCODE; // [RULE6]
            cnt_reg <= fourLineCommandMode ? OPC_EVENTS_FL : OPC_EVENTS_SPI;
            ddr_reg <= 1'b0;
          end
        ST_OPCODE:
          if (opDone && quadOp && quadEnableBit)
          begin
            state_reg <= ST_ADDR; // [RULE4] [RULE16]
            cnt_reg <= ADDR_EVENTS;
            ddr_reg <= (opWord == OP_DTR_QUAD_READ);
            wrapCmd_reg <= (opWord == OP_FL_WRAP_READ);
          end
          else if (opDone && opWord == OP_SET_WRAP && !fourLineCommandMode)
          begin
            state_reg <= ST_WRAPCFG;
            cnt_reg <= WRAP_CMD_EVENTS;
          end
          else if (opDone)
            state_reg <= ST_IGNORE;
          else if (sckRise)
            cnt_reg <= cnt_reg - 6'h01;
        ST_ADDR:
          if (addrDone)
          begin
            state_reg <= ST_MODE;
            cnt_reg <= MODE_EVENTS;
          end
          else if (sampleEv)
            cnt_reg <= cnt_reg - 6'h01;
        ST_MODE:
          if (modeDone)
          begin
            // Mode byte counted inside the configured dummy [RULE12] [RULE13] [RULE20]
            state_reg <= ST_DUMMY;
            cnt_reg <= qfr_dummy_after_mode(fourLineCommandMode, ddr_reg, readParamBits);
          end
          else if (sampleEv)
            cnt_reg <= cnt_reg - 6'h01;
        ST_DUMMY:
          if (dummyDone)
            state_reg <= ST_DATA; // [RULE1]
          else if (sckRise)
            cnt_reg <= cnt_reg - 6'h01;
        ST_WRAPCFG:
          if (wrapDone)
            state_reg <= ST_IGNORE;
          else if (sckRise)
            cnt_reg <= cnt_reg - 6'h01;
        ST_DATA: state_reg <= ST_DATA;
        ST_IGNORE: state_reg <= ST_IGNORE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Continuous read memory
  // ---------------------------------------------------------------
  // Capture wins over a clear arriving in the same cycle
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      contMode_reg <= 1'b0;
      contDdr_reg <= 1'b0;
      contWrapCmd_reg <= 1'b0;
      modeByte_reg <= 8'h00;
    end
    else if (modeDone)
    begin
      modeByte_reg <= shift_next[7:0];
      contMode_reg <= (shift_next[MODE_SEL_LSB +: 2] == CONT_MODE_KEY); // [RULE5] [RULE6]
      contDdr_reg <= ddr_reg;
      contWrapCmd_reg <= wrapCmd_reg;
    end
    else if (contModeClear)
      contMode_reg <= 1'b0; // [RULE7]
  end

  // ---------------------------------------------------------------
  // Wrap setting
  // ---------------------------------------------------------------
  // Last eight bits of the wrap command hold the setting [RULE21]
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      wrapSetting_reg <= WRAP_SETTING_RESET;
    else if (wrapDone)
      wrapSetting_reg <= shift_next[6:4]; // [RULE8] [RULE19]
  end

  // Wrap decided at data start; four-line mode uses only the dedicated opcode
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      wrapOn_reg <= 1'b0;
    else if (dummyDone)
      wrapOn_reg <= fourLineCommandMode ? wrapCmd_reg : // [RULE15]
                    (wrapSetting_reg[WRAP_ENABLE_POS] == WRAP_ENABLE_ACTIVE); // [RULE11]
  end

  // ---------------------------------------------------------------
  // Address and data output
  // ---------------------------------------------------------------
  // Any start byte; step after each low nibble, wrap inside section
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      memAddr_reg <= 24'h000000;
    else if (addrDone)
      memAddr_reg <= shift_next; // [RULE3]
    else if (outEv && nibLow_reg)
      memAddr_reg <= qfr_next_addr(memAddr_reg, wrapOn_reg,
                                   wrapSetting_reg[WRAP_LEN_LSB +: 2]); // [RULE3] [RULE9] [RULE10]
  end

  // High nibble first; IO released as soon as the frame ends
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ioOut_reg <= 4'h0;
      ioOe_reg <= 1'b0;
      nibLow_reg <= 1'b0;
    end
    else if (csN || state_reg != ST_DATA)
    begin
      ioOe_reg <= 1'b0;
      nibLow_reg <= 1'b0;
    end
    else if (outEv)
    begin
      ioOut_reg <= nibLow_reg ? memData[3:0] : memData[7:4]; // [RULE2]
      ioOe_reg <= 1'b1; // [RULE17]
      nibLow_reg <= ~nibLow_reg;
    end
  end

  assign ioPinOut = ioOut_reg;
  assign ioPinOe = {4{ioOe_reg}};
  assign memAddr = memAddr_reg;
  assign continuousModeByte = modeByte_reg;
  assign continuousModeSelectActive = contMode_reg;
  assign wrapSettingBits = wrapSetting_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic [5:0] dummySeen_reg;

  // Counts dummy clocks actually seen, for the latency checks
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      dummySeen_reg <= 6'h00;
    else if (modeDone)
      dummySeen_reg <= 6'h00;
    else if (state_reg == ST_DUMMY && sckRise)
      dummySeen_reg <= dummySeen_reg + 6'h01;
  end

  property p_oe_only_in_data;
    @(posedge clk) disable iff (sys_rst) ioOe_reg |-> state_reg == ST_DATA;
  endproperty
  a_oe_only_in_data: assert property (p_oe_only_in_data) // [RULE2]
    else $error("IO driven outside data phase");

  property p_quad_needs_enable;
    @(posedge clk) disable iff (sys_rst)
      (state_reg == ST_OPCODE) ##1 (state_reg == ST_ADDR) |-> $past(quadEnableBit);
  endproperty
  a_quad_needs_enable: assert property (p_quad_needs_enable) // [RULE4]
    else $error("Quad read accepted without quad enable");

  property p_addr_six_events;
    @(posedge clk) disable iff (sys_rst)
      $rose(state_reg == ST_ADDR) |-> cnt_reg == ADDR_EVENTS;
  endproperty
  a_addr_six_events: assert property (p_addr_six_events) // [RULE1]
    else $error("Address phase not six events long");

  property p_addr_step;
    @(posedge clk) disable iff (sys_rst)
      (outEv && nibLow_reg && !wrapOn_reg && !csN) |=>
        memAddr_reg == $past(memAddr_reg) + 24'h000001;
  endproperty
  a_addr_step: assert property (p_addr_step) // [RULE3]
    else $error("Address did not advance by one");

  property p_wrap_section;
    @(posedge clk) disable iff (sys_rst)
      (outEv && nibLow_reg && wrapOn_reg && !csN) |=>
        (memAddr_reg[23:6] == $past(memAddr_reg[23:6])) &&
        ((memAddr_reg[5:0] & ~qfr_wrap_mask(wrapSetting_reg[2:1]))
          == ($past(memAddr_reg[5:0]) & ~qfr_wrap_mask(wrapSetting_reg[2:1])));
  endproperty
  a_wrap_section: assert property (p_wrap_section) // [RULE10]
    else $error("Wrapped address left its section");

  property p_cont_frame;
    @(posedge clk) disable iff (sys_rst)
      (csFall && contMode_reg && !csN) |=> state_reg == ST_ADDR;
  endproperty
  a_cont_frame: assert property (p_cont_frame) // [RULE5]
    else $error("Continuous frame did not start with address");

  property p_normal_frame;
    @(posedge clk) disable iff (sys_rst)
      (csFall && !contMode_reg && !csN) |=> state_reg == ST_OPCODE;
  endproperty
  a_normal_frame: assert property (p_normal_frame) // [RULE6]
    else $error("Normal frame did not expect an opcode");

  property p_spi_dummy;
    @(posedge clk) disable iff (sys_rst)
      (state_reg == ST_DUMMY) ##1 (state_reg == ST_DATA) |->
        (fourLineCommandMode || dummySeen_reg == SPI_DUMMY_CLOCKS);
  endproperty
  a_spi_dummy: assert property (p_spi_dummy) // [RULE16]
    else $error("Single-line mode dummy count is not four");

  property p_fl_dummy;
    @(posedge clk) disable iff (sys_rst)
      (state_reg == ST_DUMMY) ##1 (state_reg == ST_DATA) |->
        (!fourLineCommandMode || dummySeen_reg + (ddr_reg ? MODE_CLOCKS_DDR : MODE_CLOCKS_SDR)
          == (ddr_reg ? FL_DDR_DUMMY_BASE : FL_SDR_DUMMY_BASE) + {2'h0, readParamBits, 1'b0});
  endproperty
  a_fl_dummy: assert property (p_fl_dummy) // [RULE12]
    else $error("Four-line mode dummy count wrong");

  property p_no_wrap_fl;
    @(posedge clk) disable iff (sys_rst)
      $rose(state_reg == ST_DATA) && fourLineCommandMode && !wrapCmd_reg |-> !wrapOn_reg;
  endproperty
  a_no_wrap_fl: assert property (p_no_wrap_fl) // [RULE15]
    else $error("Wrap applied to four-line mode quad read");

endmodule : qfr_engine

`default_nettype wire

// ==== qfr_host_model.sv ====
// Purpose: Host controller model for the quad read link
// Assumes: Serial clock period 125 ns, clock idle low outside frames
// Notes: A released IO line shows the inverse of its last driven value
`default_nettype none

module qfr_host_model (
  output logic csPinN,
  output logic sckPin,
  output logic [3:0] ioPinIn,
  input wire logic [3:0] ioPinOut,
  input wire logic [3:0] ioPinOe,
  output logic byteValid,
  output logic [7:0] byteSeen
);
  timeunit 1ns;
  timeprecision 10ps;

  logic [3:0] hostIo;
  logic hostOe;

  // Device owns the lines while its enable is up
  assign ioPinIn = (ioPinOe != 4'h0) ? ioPinOut : hostIo;

  // ------------------------------------------------------------
  // Link primitives
  // ------------------------------------------------------------
  initial
  begin
    csPinN = 1'b1;
    sckPin = 1'b0;
    hostIo = 4'h0;
    hostOe = 1'b1;
    byteValid = 1'b0;
    byteSeen = 8'h00;
  end

  // One serial clock: a before rise, b before fall; r and f sampled at those edges
  task automatic clk2(input logic [3:0] a, input logic [3:0] b, output logic [3:0] r,
                      output logic [3:0] f);
    if (hostOe)
      hostIo = a;
    #31.25;
    r = ioPinIn;
    sckPin = 1'b1;
    #31.25;
    if (hostOe)
      hostIo = b;
    #31.25;
    f = ioPinIn;
    sckPin = 1'b0;
    #31.25;
  endtask : clk2

  // Single-line bits on IO0, most significant first
  task automatic sendBits(input logic [31:0] v, input int n);
    logic [3:0] r, f;
    for (int i = n - 1; i >= 0; i--)
      clk2({3'h0, v[i]}, {3'h0, v[i]}, r, f);
  endtask : sendBits

  // Wrap setup: opcode, 24 dummy bits, wrap byte, deselect
  task automatic wrapCmd(input logic [7:0] w);
    csPinN = 1'b0;
    #62.5;
    sendBits(32'h00000077, 8);
    sendBits({24'h000000, w}, 32);
    csPinN = 1'b1;
    #100;
  endtask : wrapCmd

  // Read frame; each data byte is shown on byteSeen with a byteValid pulse
  task automatic frame(input logic fl, input logic ddr, input logic skipOp,
                       input logic [7:0] op, input logic [31:0] am, input int dum,
                       input int nb);
    logic [3:0] r, f, r2;
    hostOe = 1'b1;
    csPinN = 1'b0;
    #62.5;
    if (!skipOp && fl)
      for (int i = 1; i >= 0; i--)
        clk2(op[i*4+:4], op[i*4+:4], r, f);
    else if (!skipOp)
      sendBits({24'h000000, op}, 8);
    // Address then mode byte, one nibble per edge at double rate
    for (int i = 7; i >= 0; i -= (ddr ? 2 : 1))
      clk2(am[i*4+:4], am[(i-int'(ddr))*4+:4], r, f);
    // Lines let go well before the first data edge
    hostOe = 1'b0;
    hostIo = ~hostIo;
    repeat (dum)
      clk2(4'h0, 4'h0, r, f);
    for (int k = 0; k < nb; k++)
    begin
      clk2(4'h0, 4'h0, r, f);
      if (!ddr)
        clk2(4'h0, 4'h0, f, r2);
      byteSeen = {r, f};
      byteValid = 1'b1;
      #1;
      byteValid = 1'b0;
    end
    csPinN = 1'b1;
    hostOe = 1'b1;
    #100;
  endtask : frame
endmodule : qfr_host_model

`default_nettype wire

// ==== qfr_engine_tb.sv ====
// Purpose: Self-checking bench of the quad fast read engine
// Assumes: Memory byte is a fixed function of its address
// Notes: Expected bytes are queued before each frame and matched as they arrive
`default_nettype none

module qfr_engine_tb;
  timeunit 1ns;
  timeprecision 10ps;
  import qfr_pkg::*;

  logic clk, sys_rst, csPinN, sckPin, quadEnableBit, fourLineCommandMode, contModeClear;
  logic [3:0] ioPinIn, ioPinOut, ioPinOe;
  logic [2:0] readParamBits, wrapSettingBits, p;
  logic [23:0] memAddr, a;
  logic [7:0] memData, continuousModeByte, byteSeen;
  logic continuousModeSelectActive, byteValid, oeSeen;
  logic [7:0] expQ[$];
  int mismatches, samples_checked, seed;

  // Memory contents depend on the address so a wrong address shows up
  assign memData = memAddr[7:0] ^ memAddr[15:8] ^ 8'h5A;

  qfr_engine u_qfr_engine (.clk(clk), .sys_rst(sys_rst), .csPinN(csPinN), .sckPin(sckPin),
    .ioPinIn(ioPinIn), .ioPinOut(ioPinOut), .ioPinOe(ioPinOe), .quadEnableBit(quadEnableBit),
    .fourLineCommandMode(fourLineCommandMode), .readParamBits(readParamBits),
    .contModeClear(contModeClear), .memAddr(memAddr), .memData(memData),
    .continuousModeByte(continuousModeByte),
    .continuousModeSelectActive(continuousModeSelectActive), .wrapSettingBits(wrapSettingBits));
  qfr_host_model u_qfr_host_model (.csPinN(csPinN), .sckPin(sckPin), .ioPinIn(ioPinIn),
    .ioPinOut(ioPinOut), .ioPinOe(ioPinOe), .byteValid(byteValid), .byteSeen(byteSeen));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever
      #2 clk = ~clk;
  end

  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic finish_test();
    $display("Checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  // Level inputs move just after a clock edge
  task automatic cfg(input logic en, input logic fl, input logic [2:0] pp);
    @(posedge clk);
    #1;
    quadEnableBit = en;
    fourLineCommandMode = fl;
    readParamBits = pp;
  endtask : cfg

  // Notes the expected bytes, walking the address as the engine must
  task automatic rd(input logic fl, input logic ddr, input logic skip, input logic [7:0] op,
                    input logic [7:0] mode, input int dum, input int nb, input logic wrapOn,
                    input logic [1:0] len);
    logic [7:0] m;
    logic [23:0] x;
    m = (8'h08 << len) - 8'h01;
    x = a;
    for (int i = 0; i < nb; i++)
    begin
      expQ.push_back(x[7:0] ^ x[15:8] ^ 8'h5A);
      x = wrapOn ? {x[23:8], (x[7:0] & ~m) | ((x[7:0] + 8'h01) & m)} : x + 24'h000001;
    end
    u_qfr_host_model.frame(fl, ddr, skip, op, {a, mode}, dum, nb);
  endtask : rd

  // Each arriving byte is matched against the oldest note
  always @(posedge byteValid)
  begin
    if (expQ.size() == 0)
      check("surplus byte", 24'hFFFFFF, {16'h0000, byteSeen});
    else
      check("read byte", {16'h0000, expQ.pop_front()}, {16'h0000, byteSeen});
  end

  // Any device drive at all is noted for the refused frame
  always @(posedge clk)
    if (ioPinOe != 4'h0)
      oeSeen <= 1'b1;

  // Hang guard, well inside the cycle budget
  initial
  begin
    #300000;
    mismatches++;
    $display("Error timeout expected end seen none");
    finish_test();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    {seed, mismatches, samples_checked} = {32'h2D14, 32'h0, 32'h0};
    {sys_rst, quadEnableBit, fourLineCommandMode, readParamBits} = 6'h30;
    {contModeClear, oeSeen} = 2'h0;
    repeat (4) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    check("wrap bits at reset", 24'h000007, {21'h0, wrapSettingBits});
    repeat (4) @(posedge clk);
    a = 24'($random(seed));
    rd(1'b0, 1'b0, 1'b0, OP_QUAD_READ, 8'hE0, 4, 3, 1'b0, 2'h0);
    check("select armed", 24'h1, {23'h0, continuousModeSelectActive});
    a = 24'($random(seed));
    rd(1'b0, 1'b0, 1'b1, 8'h00, 8'h00, 4, 2, 1'b0, 2'h0);
    check("select dropped", 24'h0, {23'h0, continuousModeSelectActive});
    $display("Test continuous read done");
    cfg(1'b0, 1'b0, 3'h0);
    oeSeen = 1'b0;
    u_qfr_host_model.frame(1'b0, 1'b0, 1'b0, OP_QUAD_READ, {a, 8'h20}, 12, 0);
    check("drive while quad off", 24'h0, {23'h0, oeSeen});
    cfg(1'b1, 1'b0, 3'h0);
    $display("Test quad enable done");
    for (int len = 0; len < 4; len++)
    begin
      u_qfr_host_model.wrapCmd({1'b0, 2'(len), WRAP_ENABLE_ACTIVE, 4'h0});
      check("wrap bits", {21'h0, 2'(len), WRAP_ENABLE_ACTIVE}, {21'h0, wrapSettingBits});
      a = 24'($random(seed));
      rd(1'b0, 1'b0, 1'b0, OP_QUAD_READ, 8'h00, 4, (8 << len) + 3, 1'b1, 2'(len));
    end
    $display("Test wrap lengths done");
    a = 24'($random(seed));
    rd(1'b0, 1'b1, 1'b0, OP_DTR_QUAD_READ, 8'h2F, 4, 5, 1'b1, 2'h3);
    check("mode byte", 24'h00002F, {16'h0000, continuousModeByte});
    a = 24'($random(seed));
    rd(1'b0, 1'b1, 1'b1, 8'h00, 8'h2F, 4, 3, 1'b1, 2'h3);
    @(posedge clk);
    #1;
    contModeClear = 1'b1;
    @(posedge clk);
    #1;
    contModeClear = 1'b0;
    repeat (2) @(posedge clk);
    check("select after clear", 24'h0, {23'h0, continuousModeSelectActive});
    $display("Test double rate done");
    u_qfr_host_model.wrapCmd({3'h0, WRAP_ENABLE_ACTIVE, 4'h0});
    cfg(1'b1, 1'b1, 3'h0);
    a = 24'($random(seed));
    rd(1'b1, 1'b0, 1'b0, OP_QUAD_READ, 8'h20, 2, 10, 1'b0, 2'h0);
    rd(1'b1, 1'b0, 1'b1, 8'h00, 8'h00, 2, 2, 1'b0, 2'h0);
    rd(1'b1, 1'b0, 1'b0, OP_FL_WRAP_READ, 8'h00, 2, 10, 1'b1, 2'h0);
    p = 3'($random(seed));
    cfg(1'b1, 1'b1, p);
    rd(1'b1, 1'b1, 1'b0, OP_DTR_QUAD_READ, 8'h00, 5 + 2 * int'(p), 3, 1'b0, 2'h0);
    rd(1'b1, 1'b0, 1'b0, OP_QUAD_READ, 8'h00, 2 + 2 * int'(p), 3, 1'b0, 2'h0);
    $display("Test four-line mode done");
    repeat (20) @(posedge clk);
    check("bytes left", 24'h0, 24'(expQ.size()));
    finish_test();
  end
endmodule : qfr_engine_tb

`default_nettype wire
